// [logic/pil_interlock.sv]
/*
 Start permission and process interlock logic with an APB register file.
 Assumes switch pins are asynchronous and START_DONE comes from this clock.
*/
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "pil_consts.svh"
module pil_interlock #(
    parameter int TICK_CYCLES = `PIL_CLK_HZ * `PIL_TICK_S
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Field switches and motor state
    input wire logic [`PIL_NUM_IN-1:0] SW_IN,
    input wire logic MANUAL_START_SW,
    input wire logic AUTO_START_SW,
    input wire logic MOTOR_RUN,
    input wire logic START_DONE,
    // Results
    output logic START_GRANT,
    output logic TRIP_OUT,
    output logic STOP_OUT,
    output logic ALARM_OUT,
    output logic MODE_AUTO,
    output logic AUTO_LAMP
);
    import pil_pkg::*;

    localparam int N = `PIL_NUM_IN;

    // Bus state and registers
    pil_bus_state_t bus_r;
    logic [31:0] ctrl_r;
    pil_func_t fn_r [N];
    logic [N-1:0] nc_r, inst_en_r, stop_sel_r, su_off_r, ru_off_r;
    pil_dly_t su_dly_r [N];
    pil_dly_t ru_dly_r [N];
    pil_dly_t cnt_r [N];
    logic [N-1:0] trip_r, stop_r, phase_r;
    logic block_r, blk_alarm_r, mode_auto_r, mode_rej_r, cfg_rej_r, start_ref_r;
    logic [26:0] tick_cnt_r;
    logic tick_r, man_d_r, auto_d_r;
    logic [N+2:0] pins_s;
    logic [31:0] name_rdata;

    // Is the code one of the ten process interlock functions
    function automatic logic is_pi_fn(input pil_func_t f);
        return (f >= `PIL_FN_PI_FIRST) && (f <= `PIL_FN_PI_LAST);
    endfunction

    // Expiry when the second count exceeds the setting
    function automatic logic expired(input pil_dly_t cnt, input pil_dly_t dly);
        return cnt > dly;
    endfunction

    // Another input already holds this function
    function automatic logic fn_taken(input pil_func_t f, input logic [3:0] self);
        logic hit;
        hit = 1'b0;
        for (int j = 0; j < N; j++) begin
            if (j[3:0] != self && fn_r[j] == f && f != 5'h00) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    pil_sync #(.WIDTH(N + 3)) u_sync (
        .clk(CLK),
        .rst_n(RESET_N),
        .din({MOTOR_RUN, AUTO_START_SW, MANUAL_START_SW, SW_IN}),
        .dout(pins_s)
    );

    wire [N-1:0] closed = pins_s[N-1:0];
    wire man_s = pins_s[N];
    wire auto_s = pins_s[N+1];
    wire run_s = pins_s[N+2];

    // Control fields
    wire sb_en = ctrl_r[0];
    wire sb_alarm_en = ctrl_r[1];
    wire chg_run_en = ctrl_r[2];
    wire auto_hw = ctrl_r[3];
    wire auto_lamp_usage_select = ctrl_r[4];

    // Address decode
    wire acc = PSEL && PENABLE && bus_r == PIL_BUS_ACK;
    wire wr = acc && PWRITE;
    wire [3:0] idx = PADDR[5:2];
    wire idx_ok = idx < 4'(N);
    wire hit_ctrl = PADDR == `PIL_CTRL_OFS;
    wire hit_cmd = PADDR == `PIL_CMD_OFS;
    wire hit_stat = PADDR == `PIL_STAT_OFS;
    wire hit_in = PADDR == `PIL_INPUT_OFS;
    wire hit_ev = PADDR == `PIL_EVENT_OFS;
    wire hit_cfg = PADDR[11:6] == `PIL_CFG_BASE && PADDR[1:0] == 2'h0 && idx_ok;
    wire hit_dly = PADDR[11:6] == `PIL_DLY_BASE && PADDR[1:0] == 2'h0 && idx_ok;
    wire [5:0] name_idx = PADDR[7:2];
    wire hit_name = PADDR[11:8] == `PIL_NAME_BASE && PADDR[1:0] == 2'h0
        && name_idx < 6'(`PIL_NAME_WORDS);
    wire hit_any = hit_ctrl || hit_cmd || hit_stat || hit_in || hit_ev || hit_cfg
        || hit_dly || hit_name;

    // Command strobes, one per accepted write
    wire cmd_wr = wr && hit_cmd;
    wire cmd_block = cmd_wr && PWDATA[0];
    wire cmd_unblock = cmd_wr && PWDATA[1];
    wire cmd_start = cmd_wr && PWDATA[2];
    wire cmd_auto = cmd_wr && PWDATA[3];
    wire cmd_manual = cmd_wr && PWDATA[4];
    wire cmd_reset = cmd_wr && PWDATA[5];
    wire cmd_alarm_clr = cmd_wr && PWDATA[6];

    // Configuration write checks: unique function, delays in range
    wire cfg_wr = wr && hit_cfg;
    wire cfg_bad = fn_taken(PWDATA[4:0], idx);
    wire dly_wr = wr && hit_dly;
    wire dly_bad = PWDATA[11:0] > `PIL_DLY_MAX || PWDATA[27:16] > `PIL_DLY_MAX;

    // Per-input health, supervision and expiry
    logic [N-1:0] is_pi, unh, sup_su, sup_ru, expire, zero_hold, inst_now;
    always_comb begin
        for (int i = 0; i < N; i++) begin
            is_pi[i] = is_pi_fn(fn_r[i]);
            unh[i] = nc_r[i] ? closed[i] : ~closed[i];
            sup_su[i] = is_pi[i] && run_s && !START_DONE && !su_off_r[i];
            sup_ru[i] = is_pi[i] && run_s && START_DONE && !ru_off_r[i];
            expire[i] = unh[i] && ((sup_su[i] && expired(cnt_r[i], su_dly_r[i]))
                || (sup_ru[i] && expired(cnt_r[i], ru_dly_r[i])));
            zero_hold[i] = is_pi[i] && !su_off_r[i] && su_dly_r[i] == 12'h000 && unh[i];
            inst_now[i] = is_pi[i] && inst_en_r[i] && unh[i];
        end
    end

    // Start requests by command source and mode
    wire man_rise = man_s && !man_d_r;
    wire auto_rise = auto_s && !auto_d_r;
    wire start_req = mode_auto_r ? (auto_hw ? auto_rise : cmd_start) : man_rise;
    wire block_hit = start_req && block_r;
    wire refuse = block_hit || (|zero_hold) || (|trip_r);
    wire mode_req = cmd_auto || cmd_manual;
    wire mode_ok = !run_s || chg_run_en;

    // Read data selection
    wire [31:0] stat_word = {25'h0, start_ref_r, cfg_rej_r, mode_rej_r, run_s,
        mode_auto_r, blk_alarm_r, block_r};
    wire [31:0] cfg_word = {22'h0, ru_off_r[idx], su_off_r[idx], stop_sel_r[idx],
        inst_en_r[idx], nc_r[idx], fn_r[idx]};
    wire [31:0] dly_word = {4'h0, ru_dly_r[idx], 4'h0, su_dly_r[idx]};
    wire [31:0] rd_word = hit_ctrl ? ctrl_r
        : hit_stat ? stat_word
        : hit_in ? {6'h0, inst_now, 6'h0, ~unh}
        : hit_ev ? {6'h0, stop_r, 6'h0, trip_r}
        : hit_cfg ? cfg_word
        : hit_dly ? dly_word
        : hit_name ? name_rdata
        : 32'h0;

    pil_name_store u_names (
        .clk(CLK),
        .rst_n(RESET_N),
        .we(wr && hit_name),
        .idx(name_idx),
        .wdata(PWDATA),
        .rdata(name_rdata)
    );

    // APB handshake: one wait state so every answer comes from a flop
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            bus_r <= PIL_BUS_IDLE;
            PREADY <= 1'b0;
            PRDATA <= 32'h0;
            PSLVERR <= 1'b0;
        end else begin
            case (bus_r)
                PIL_BUS_IDLE: begin
                    if (PSEL && PENABLE) begin
                        bus_r <= PIL_BUS_ACK;
                        PREADY <= 1'b1;
                        PRDATA <= PWRITE ? 32'h0 : rd_word;
                        PSLVERR <= !hit_any;
                    end
                end
                PIL_BUS_ACK: begin
                    bus_r <= PIL_BUS_IDLE;
                    PREADY <= 1'b0;
                    PSLVERR <= 1'b0;
                end
                default: bus_r <= PIL_BUS_IDLE;
            endcase
        end
    end

    // Control register and per-input settings
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_r <= `PIL_CTRL_RESET;
            cfg_rej_r <= 1'b0;
            for (int i = 0; i < N; i++) begin
                {ru_off_r[i], su_off_r[i], stop_sel_r[i], inst_en_r[i], nc_r[i], fn_r[i]}
                    <= `PIL_CFG_RESET;
                su_dly_r[i] <= `PIL_DLY_RESET;
                ru_dly_r[i] <= `PIL_DLY_RESET;
            end
        end else begin
            if (wr && hit_ctrl) begin
                ctrl_r <= {27'h0, PWDATA[4:0]};
            end
            if (cfg_wr) begin
                cfg_rej_r <= cfg_bad;
                if (!cfg_bad) begin
                    {ru_off_r[idx], su_off_r[idx], stop_sel_r[idx], inst_en_r[idx],
                        nc_r[idx], fn_r[idx]} <= PWDATA[9:0];
                end
            end else if (dly_wr) begin
                cfg_rej_r <= dly_bad;
                if (!dly_bad) begin
                    su_dly_r[idx] <= PWDATA[11:0];
                    ru_dly_r[idx] <= PWDATA[27:16];
                end
            end
        end
    end

    // One-second tick; long count shortened through the parameter
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tick_cnt_r <= 27'h0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= tick_cnt_r == 27'(TICK_CYCLES - 1);
            tick_cnt_r <= (tick_cnt_r == 27'(TICK_CYCLES - 1)) ? 27'h0 : tick_cnt_r + 27'h1;
        end
    end

    // Supervision timers restart on health, stop, or change of phase
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < N; i++) begin
                cnt_r[i] <= 12'h000;
            end
            phase_r <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                phase_r[i] <= START_DONE;
                if (!unh[i] || !(sup_su[i] || sup_ru[i]) || phase_r[i] != START_DONE) begin
                    cnt_r[i] <= 12'h000;
                end else if (tick_r && cnt_r[i] != 12'hFFF) begin
                    cnt_r[i] <= cnt_r[i] + 12'h001;
                end
            end
        end
    end

    // Trips latch until reset; stops last until the motor stops. Set beats clear.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            trip_r <= '0;
            stop_r <= '0;
        end else begin
            trip_r <= (cmd_reset ? '0 : trip_r) | (expire & ~stop_sel_r);
            stop_r <= (run_s ? stop_r : '0) | (expire & stop_sel_r);
        end
    end

    // Serial block, block alarm, command mode and start decision
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            block_r <= 1'b0;
            blk_alarm_r <= 1'b0;
            mode_auto_r <= 1'b0;
            mode_rej_r <= 1'b0;
            start_ref_r <= 1'b0;
            man_d_r <= 1'b0;
            auto_d_r <= 1'b0;
        end else begin
            man_d_r <= man_s;
            auto_d_r <= auto_s;
            if (!sb_en) begin
                block_r <= 1'b0;
            end else if (cmd_block) begin
                block_r <= 1'b1;
            end else if (cmd_unblock) begin
                block_r <= 1'b0;
            end
            if (block_hit && sb_alarm_en) begin
                blk_alarm_r <= 1'b1;
            end else if (cmd_alarm_clr) begin
                blk_alarm_r <= 1'b0;
            end
            if (mode_req) begin
                mode_rej_r <= !mode_ok;
                if (mode_ok) begin
                    mode_auto_r <= cmd_auto;
                end
            end
            if (start_req) begin
                start_ref_r <= refuse;
            end
        end
    end

    // Top-level outputs, all from flops
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            START_GRANT <= 1'b0;
            TRIP_OUT <= 1'b0;
            STOP_OUT <= 1'b0;
            ALARM_OUT <= 1'b0;
            MODE_AUTO <= 1'b0;
            AUTO_LAMP <= 1'b0;
        end else begin
            START_GRANT <= start_req && !refuse;
            TRIP_OUT <= |trip_r;
            STOP_OUT <= |stop_r;
            ALARM_OUT <= (|inst_now) || blk_alarm_r;
            MODE_AUTO <= mode_auto_r;
            AUTO_LAMP <= mode_auto_r && (auto_lamp_usage_select || !auto_hw);
        end
    end

    // Checks on the logic above
    a_block_inhibit: assert property (@(posedge CLK) disable iff (!RESET_N)
        start_req && block_r |=> !START_GRANT)
        else $error("start granted while blocked");
    a_block_needs_en: assert property (@(posedge CLK) disable iff (!RESET_N)
        cmd_block && !sb_en && !block_r |=> !block_r)
        else $error("block taken while enable off");
    a_block_dropped: assert property (@(posedge CLK) disable iff (!RESET_N)
        $fell(sb_en) |=> !block_r)
        else $error("block survived enable off");
    a_block_alarm: assert property (@(posedge CLK) disable iff (!RESET_N)
        block_hit && sb_alarm_en |=> blk_alarm_r ##1 ALARM_OUT)
        else $error("block alarm missing");
    a_mode_accept: assert property (@(posedge CLK) disable iff (!RESET_N)
        cmd_auto && chg_run_en |=> mode_auto_r ##1 MODE_AUTO)
        else $error("mode change not taken");
    a_mode_reject: assert property (@(posedge CLK) disable iff (!RESET_N)
        mode_req && run_s && !chg_run_en |=> mode_auto_r == $past(mode_auto_r) && mode_rej_r)
        else $error("mode changed while running");
    a_zero_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
        start_req && (|zero_hold) |=> !START_GRANT && start_ref_r)
        else $error("start with unhealthy zero-delay input");
    a_trip_held: assert property (@(posedge CLK) disable iff (!RESET_N)
        trip_r[0] && !cmd_reset |=> trip_r[0] ##1 TRIP_OUT)
        else $error("trip dropped without reset");
    a_inst_alarm: assert property (@(posedge CLK) disable iff (!RESET_N)
        (|inst_now) |=> ALARM_OUT)
        else $error("instant alarm late");
    a_run_off: assert property (@(posedge CLK) disable iff (!RESET_N)
        ru_off_r[0] && START_DONE |-> !expire[0])
        else $error("expiry with running delay off");
endmodule

// [logic/pil_name_store.sv]
/*
 Storage for the names of the process interlock functions, five words each.
 Assumes the caller has checked the word index.
*/
`timescale 1ns/1ps
`include "pil_consts.svh"
module pil_name_store (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write and read port
    input wire logic we,
    input wire logic [5:0] idx,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata
);
    logic [31:0] mem_r [`PIL_NAME_WORDS];

    // Four characters per word, twenty per function
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `PIL_NAME_WORDS; i++) begin
                mem_r[i] <= 32'h0;
            end
        end else if (we) begin
            mem_r[idx] <= wdata;
        end
    end

    assign rdata = mem_r[idx];
endmodule

// [logic/pil_sync.sv]
/*
 Two-flop synchroniser for switch pins.
 Assumes inputs are asynchronous levels held for many clocks.
*/
`timescale 1ns/1ps
module pil_sync #(
    parameter int WIDTH = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins in, synchronised out
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule

// [pkg/pil_consts.svh]
/*
 Register map, function codes, delay limit, reset values and timing counts for the
 process interlock logic. Assumes one 125 MHz clock and a 32-bit APB bus.
*/
// Function
// - While serial block is enabled, a block command inhibits all starts until unblocked.
// - Turning the serial block enable off clears any active block at once.
// - With the block alarm option on, a start under block raises an alarm.
// - Mode change while running is accepted when the run-time change option is on.
// - Mode change is rejected while running when that option is off.
// - Ten programmable inputs, each with its own function, delays and alarm settings.
// - A function already held by another input cannot be assigned again.
// - During start, unhealthy longer than start-up delay raises trip or stop.
// - Start-up delay of zero refuses a start unless the input is healthy.
// - Start-up delay off disables start-up supervision.
// - After start, unhealthy longer than running delay raises trip or stop.
// - Running delay off means no trip or stop after start.
// - Per input, an event is a latched trip needing reset, or a stop.
// - Undelayed_unhealthy_alarm follows the unhealthy input without delay when enabled.
// - A twenty-character name is stored per process interlock function.
// - Healthy is closed for normally open, open for normally closed.
// - Delays run zero to 3600 seconds in one-second steps, or off.
// - Serial auto takes serial starts only; hard-wired auto takes switch starts only.
`ifndef PIL_CONSTS_SVH
`define PIL_CONSTS_SVH

`define PIL_CTRL_OFS 12'h000
`define PIL_CMD_OFS 12'h004
`define PIL_STAT_OFS 12'h008
`define PIL_INPUT_OFS 12'h00C
`define PIL_EVENT_OFS 12'h010
`define PIL_CFG_BASE 6'h01
`define PIL_DLY_BASE 6'h02
`define PIL_NAME_BASE 4'h1

`define PIL_NUM_IN 10
`define PIL_NAME_WORDS 50
`define PIL_FN_PI_FIRST 5'h01
`define PIL_FN_PI_LAST 5'h0A
`define PIL_DLY_MAX 12'hE10

`define PIL_CTRL_RESET 32'h0000_0000
`define PIL_CFG_RESET 10'h000
`define PIL_DLY_RESET 12'h000

`define PIL_CLK_HZ 125000000
`define PIL_TICK_S 1
`endif

// [pkg/pil_pkg.sv]
/*
 Types shared by the process interlock logic.
 Assumes the constants header is included by each user.
*/
package pil_pkg;
    typedef logic [4:0] pil_func_t;
    typedef logic [11:0] pil_dly_t;
    typedef enum logic [1:0] {
        PIL_BUS_IDLE = 2'b01,
        PIL_BUS_ACK = 2'b10
    } pil_bus_state_t;
endpackage

// [tb/pil_field_model.sv]
/*
 Field side model: interlock switch contacts, start switches and a motor
 contactor that closes on a start grant and opens on a trip or a stop.
 Assumes the bench asks for contact changes on the clock of the block.
*/
`timescale 1ns/1ps
module pil_field_model #(
    parameter int DONE_CYC = 300
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Requests from the bench
    input wire logic [9:0] open_req,
    input wire logic man_req,
    input wire logic auto_req,
    input wire logic stop_req,
    // Results from the block
    input wire logic start_grant,
    input wire logic trip_out,
    input wire logic stop_out,
    // Pins towards the block
    output logic [9:0] sw_in,
    output logic manual_start_sw,
    output logic auto_start_sw,
    output logic motor_run,
    output logic start_done
);
    logic [9:0] cnt_r;

    // Contacts move after the edge; the contactor follows grant and stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_in <= 10'h3FF;
            manual_start_sw <= 1'b0;
            auto_start_sw <= 1'b0;
            motor_run <= 1'b0;
            start_done <= 1'b0;
            cnt_r <= 10'h000;
        end else begin
            sw_in <= ~open_req; // Closed contact reads 1
            manual_start_sw <= man_req;
            auto_start_sw <= auto_req;
            if (start_grant) begin
                motor_run <= 1'b1;
            end else if (trip_out || stop_out || stop_req) begin
                motor_run <= 1'b0; // Contactor drops out on any stop
            end
            // Start completes a fixed time after the contactor closes
            if (!motor_run) begin
                cnt_r <= 10'h000;
                start_done <= 1'b0;
            end else if (cnt_r == DONE_CYC[9:0]) begin
                start_done <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 10'h001;
            end
        end
    end
endmodule

// [tb/pil_interlock_tb_top.sv]
/*
 Self-checking bench for the process interlock block over APB.
 Assumes a shortened one-second tick of 20 clocks and the field model.
*/
`timescale 1ns/1ps
`include "pil_consts.svh"
module pil_interlock_tb_top;
    localparam logic [11:0] CFG0 = 12'h040;
    localparam logic [11:0] DLY0 = 12'h080;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0, rdv, PRDATA;
    logic [9:0] open_q = 10'h000, SW_IN;
    logic man_q = 1'b0, auto_q = 1'b0, stop_q = 1'b0, saw_stop = 1'b0, err;
    logic PREADY, PSLVERR, MANUAL_START_SW, AUTO_START_SW, MOTOR_RUN, START_DONE;
    logic START_GRANT, TRIP_OUT, STOP_OUT, ALARM_OUT, MODE_AUTO, AUTO_LAMP;
    int n_fail = 0, checked = 0, n_grant = 0, g;

    // Clock, 8 ns period
    always #4 CLK = ~CLK;
    // Grant pulses are counted and stop events flagged as they stand
    always @(posedge CLK) begin
        if (START_GRANT === 1'b1) n_grant <= n_grant + 1;
        if (STOP_OUT === 1'b1) saw_stop <= 1'b1;
    end

    pil_interlock #(.TICK_CYCLES(20)) DUT (.CLK(CLK), .RESET_N(RESET_N), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .SW_IN(SW_IN), .MANUAL_START_SW(MANUAL_START_SW),
        .AUTO_START_SW(AUTO_START_SW), .MOTOR_RUN(MOTOR_RUN), .START_DONE(START_DONE),
        .START_GRANT(START_GRANT), .TRIP_OUT(TRIP_OUT), .STOP_OUT(STOP_OUT),
        .ALARM_OUT(ALARM_OUT), .MODE_AUTO(MODE_AUTO), .AUTO_LAMP(AUTO_LAMP));
    pil_field_model FLD (.clk(CLK), .rst_n(RESET_N), .open_req(open_q), .man_req(man_q),
        .auto_req(auto_q), .stop_req(stop_q), .start_grant(START_GRANT),
        .trip_out(TRIP_OUT), .stop_out(STOP_OUT), .sw_in(SW_IN),
        .manual_start_sw(MANUAL_START_SW), .auto_start_sw(AUTO_START_SW),
        .motor_run(MOTOR_RUN), .start_done(START_DONE));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // One APB transfer; request held until PREADY is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge CLK);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; padr <= a; pwd <= d;
        @(posedge CLK);
        pen <= 1'b1;
        do begin
            @(posedge CLK);
            k++;
        end while (PREADY !== 1'b1 && k < 20);
        if (k >= 20) chk(32'h0, 32'h1);
        rdv = PRDATA;
        err = PSLVERR;
        psel <= 1'b0; pen <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv & m, e);
    endtask

    // Serial start command; grants counted over the next cycles
    task automatic sstart(input int e);
        g = n_grant;
        wr(`PIL_CMD_OFS, 32'h4);
        repeat (4) @(posedge CLK);
        chk(32'(n_grant - g), 32'(e));
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #(8 * 30000);
        n_fail++;
        results();
    end

    initial begin
        repeat (10) @(posedge CLK);
        RESET_N <= 1'b1;
        rdm(`PIL_CTRL_OFS, 32'hFFFF_FFFF, 32'h0);
        rdm(`PIL_STAT_OFS, 32'hFFFF_FFFF, 32'h0);
        rdm(12'hFFC, 32'hFFFF_FFFF, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        // Serial start block
        wr(`PIL_CMD_OFS, 32'h1);
        rdm(`PIL_STAT_OFS, 32'h1, 32'h0);
        wr(`PIL_CTRL_OFS, 32'h3);
        wr(`PIL_CMD_OFS, 32'h1);
        rdm(`PIL_STAT_OFS, 32'h1, 32'h1);
        wr(`PIL_CMD_OFS, 32'h8);
        sstart(0);
        rdm(`PIL_STAT_OFS, 32'h2, 32'h2);
        chk({31'h0, ALARM_OUT}, 32'h1);
        wr(`PIL_CMD_OFS, 32'h10);
        g = n_grant;
        @(posedge CLK) man_q <= 1'b1;
        repeat (8) @(posedge CLK);
        man_q <= 1'b0;
        chk(32'(n_grant - g), 32'h0);
        wr(`PIL_CMD_OFS, 32'h2);
        rdm(`PIL_STAT_OFS, 32'h1, 32'h0);
        wr(`PIL_CMD_OFS, 32'h1);
        wr(`PIL_CTRL_OFS, 32'h2);
        rdm(`PIL_STAT_OFS, 32'h1, 32'h0);
        wr(`PIL_CMD_OFS, 32'h40);
        wr(`PIL_CTRL_OFS, 32'h0);
        $display("test block done");
        // Configuration checks
        wr(CFG0, 32'h41);
        rdm(CFG0, 32'hFFFF_FFFF, 32'h41);
        wr(CFG0 + 12'h024, 32'h0A);
        rdm(CFG0 + 12'h024, 32'hFFFF_FFFF, 32'h0A);
        wr(CFG0 + 12'h004, 32'h01);
        rdm(`PIL_STAT_OFS, 32'h20, 32'h20);
        rdm(CFG0 + 12'h004, 32'hFFFF_FFFF, 32'h0);
        wr(DLY0, 32'hE10);
        rdm(`PIL_STAT_OFS, 32'h20, 32'h0);
        wr(DLY0, 32'hE11);
        rdm(`PIL_STAT_OFS, 32'h20, 32'h20);
        rdm(DLY0, 32'hFFFF_FFFF, 32'hE10);
        wr(12'h1C4, 32'h4D4F_544F);
        rdm(12'h1C4, 32'hFFFF_FFFF, 32'h4D4F_544F);
        $display("test config done");
        // Health and undelayed alarm
        @(posedge CLK) open_q <= 10'h001;
        repeat (6) @(posedge CLK);
        rdm(`PIL_INPUT_OFS, 32'h1_0001, 32'h1_0000);
        chk({31'h0, ALARM_OUT}, 32'h1);
        wr(CFG0, 32'h61);
        rdm(`PIL_INPUT_OFS, 32'h1_0001, 32'h1);
        wr(CFG0, 32'h01);
        $display("test health done");
        // Zero and off start-up delay
        wr(DLY0, 32'h0);
        wr(`PIL_CMD_OFS, 32'h8);
        sstart(0);
        rdm(`PIL_STAT_OFS, 32'h40, 32'h40);
        wr(CFG0, 32'h101);
        sstart(1);
        repeat (60) @(posedge CLK);
        chk({31'h0, TRIP_OUT}, 32'h0);
        @(posedge CLK) stop_q <= 1'b1;
        @(posedge CLK) stop_q <= 1'b0;
        repeat (4) @(posedge CLK);
        $display("test zero delay done");
        // Start-up trip, latched until reset
        wr(CFG0, 32'h01);
        wr(DLY0, 32'h2);
        sstart(1);
        repeat (26) @(posedge CLK);
        chk({31'h0, TRIP_OUT}, 32'h0);
        repeat (70) @(posedge CLK);
        chk({31'h0, TRIP_OUT}, 32'h1);
        rdm(`PIL_EVENT_OFS, 32'h1, 32'h1);
        @(posedge CLK) open_q <= 10'h000;
        repeat (6) @(posedge CLK);
        sstart(0);
        wr(`PIL_CMD_OFS, 32'h20);
        sstart(1);
        $display("test startup trip done");
        // Mode changes while running, then running stop
        repeat (320) @(posedge CLK);
        wr(`PIL_CMD_OFS, 32'h10);
        rdm(`PIL_STAT_OFS, 32'h14, 32'h14);
        chk({30'h0, MODE_AUTO, AUTO_LAMP}, 32'h3);
        wr(`PIL_CTRL_OFS, 32'h4);
        wr(`PIL_CMD_OFS, 32'h10);
        rdm(`PIL_STAT_OFS, 32'h14, 32'h0);
        wr(`PIL_CMD_OFS, 32'h8);
        wr(CFG0, 32'h81);
        wr(DLY0, 32'h1_0002);
        @(posedge CLK) open_q <= 10'h001;
        repeat (14) @(posedge CLK);
        chk({31'h0, saw_stop}, 32'h0);
        repeat (70) @(posedge CLK);
        chk({31'h0, saw_stop}, 32'h1);
        chk({30'h0, TRIP_OUT, MOTOR_RUN}, 32'h0);
        $display("test running stop done");
        // Running delay off keeps the motor on
        wr(CFG0, 32'h381);
        saw_stop = 1'b0;
        sstart(1);
        repeat (400) @(posedge CLK);
        chk({30'h0, saw_stop, MOTOR_RUN}, 32'h1);
        @(posedge CLK) stop_q <= 1'b1;
        @(posedge CLK) stop_q <= 1'b0;
        $display("test running off done");
        // Hard-wired auto takes switch starts only
        wr(`PIL_CTRL_OFS, 32'h8);
        sstart(0);
        g = n_grant;
        @(posedge CLK) auto_q <= 1'b1;
        repeat (8) @(posedge CLK);
        auto_q <= 1'b0;
        chk(32'(n_grant - g), 32'h1);
        chk({30'h0, MODE_AUTO, AUTO_LAMP}, 32'h2);
        $display("test auto source done");
        results();
    end
endmodule
